// ===== design/uart_enhanced_baud_lin.sv
// Baud generator, clock output, LIN engine and transmit FIFO of the first serial port
`timescale 1ns/1ps
`default_nettype none
`include "uart_enh_consts.svh"

// ============================================================
// Transmit FIFO
module tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = count != AW'(0) + (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + AW'(1);
            if (pop)
                rd_ptr <= rd_ptr + AW'(1);
            if (push && !pop)
                count <= count + (AW+1)'(1);
            else if (pop && !push)
                count <= count - (AW+1)'(1);
        end
    end
endmodule : tx_fifo

// ============================================================
// Top
module uart_enhanced_baud_lin #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_we,
    input wire logic sfr_re,
    output logic [7:0] sfr_rdata,
    input wire logic window_select,
    input wire logic [2:0] serial_mode,
    input wire logic default_tick,
    output logic gen_overflow,
    output logic tx_tick,
    output logic rx_tick,
    output logic timer_only,
    output logic lin_mode,
    output logic auto_repeat_tx,
    output logic [7:0] address_mask_reg,
    output logic clock_out_pin,
    output logic clock_out_pin_oe,
    input wire logic lin_rx_pin,
    input wire logic engine_tx_level,
    output logic lin_tx_out,
    output logic tx_flag_set,
    output logic rx_flag_set,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic buf_ready
);
    logic [7:0] baud_reload;
    logic [7:0] baud_counter;
    logic [7:0] enhanced_control;
    logic [7:0] lin_config;
    logic [3:0] pre_cnt;
    logic [3:0] sub_cnt;
    logic [4:0] bit_cnt;
    logic [2:0] fall_cnt;
    logic [15:0] meas;
    logic clk_toggle;
    logic rx_meta;
    logic rx_s;
    logic rx_prev;
    uart_enh_pkg::lin_state_t state;
    uart_enh_pkg::lin_state_t next_state;

    // ============================================================
    // Register decode
    wire wr_rel = sfr_we && sfr_addr == `UE_ADDR_RELOAD;
    wire wr_cnt = sfr_we && sfr_addr == `UE_ADDR_COUNTER;
    wire wr_lin = sfr_we && sfr_addr == `UE_ADDR_LIN_CFG;
    wire wr_buf = sfr_we && sfr_addr == `UE_ADDR_BUFFER;
    wire wr_shared = sfr_we && sfr_addr == `UE_ADDR_SHARED;
    wire wr_enh = wr_shared && window_select;
    wire wr_mask = wr_shared && !window_select;
    wire gen_run = enhanced_control[`UE_BIT_RUN];
    wire gen_clock_undivided = enhanced_control[`UE_BIT_UNDIV];
    wire tx_clock_from_gen = enhanced_control[`UE_BIT_TXGEN];
    wire rx_clock_from_gen = enhanced_control[`UE_BIT_RXGEN];
    wire clock_out_enable = enhanced_control[`UE_BIT_CKOE];
    wire long_break_select = lin_config[`UE_BIT_LONG];
    wire auto_baud = lin_config[`UE_BIT_ABR];
    wire lin_direction = lin_config[`UE_BIT_DIR];
    wire break_control = lin_config[`UE_BIT_BRKC];
    wire [7:0] shared_rd = window_select ? enhanced_control : address_mask_reg;
    wire [7:0] rd_val = sfr_addr == `UE_ADDR_RELOAD ? baud_reload :
                        sfr_addr == `UE_ADDR_COUNTER ? baud_counter :
                        sfr_addr == `UE_ADDR_LIN_CFG ? lin_config :
                        sfr_addr == `UE_ADDR_SHARED ? shared_rd : `UE_RESET_BYTE;

    // ============================================================
    // Baud generator
    wire pre_wrap = pre_cnt == `UE_PRESCALE_LAST;
    wire gen_clk_en = gen_clock_undivided || pre_wrap;
    wire count_en = gen_run && gen_clk_en;
    wire ovf = count_en && baud_counter == `UE_COUNTER_FULL;
    wire abr_load;
    wire [7:0] abr_val = `UE_RESET_BYTE - meas[14:7];

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            pre_cnt <= '0;
        else
            pre_cnt <= pre_wrap ? 4'h0 : pre_cnt + 4'h1;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            baud_counter <= `UE_RESET_BYTE;
            baud_reload <= `UE_RESET_BYTE;
            gen_overflow <= 1'b0;
        end
        else
        begin
            gen_overflow <= ovf;
            if (wr_rel)
                baud_reload <= sfr_wdata;
            else if (abr_load)
                baud_reload <= abr_val;
            if (wr_cnt)
                baud_counter <= sfr_wdata;
            else if (wr_rel && !gen_run)
                baud_counter <= sfr_wdata;
            else if (abr_load)
                baud_counter <= abr_val;
            else if (ovf)
                baud_counter <= baud_reload;
            else if (count_en)
                baud_counter <= baud_counter + 8'h01;
        end
    end

    // ============================================================
    // Time base selection
    wire mode_fixed9 = serial_mode == `UE_MODE_FIXED9;
    wire both_sel = tx_clock_from_gen && rx_clock_from_gen;
    assign timer_only = mode_fixed9 && both_sel;
    assign lin_mode = serial_mode == `UE_MODE_LIN && both_sel;
    // Modes 001/011 and one-select 010 all reduce to a per-direction choice
    assign tx_tick = timer_only ? 1'b0 : tx_clock_from_gen ? gen_overflow : default_tick;
    assign rx_tick = timer_only ? 1'b0 : rx_clock_from_gen ? gen_overflow : default_tick;
    assign auto_repeat_tx = enhanced_control[`UE_BIT_ART];
    assign clock_out_pin = clk_toggle && clock_out_enable;
    assign clock_out_pin_oe = clock_out_enable;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            clk_toggle <= 1'b0;
        else if (gen_overflow)
            clk_toggle <= !clk_toggle;
    end

    // ============================================================
    // LIN engine
    wire bit_tick = gen_overflow && sub_cnt == `UE_OVF_PER_BIT_LAST;
    wire rx_fall = rx_prev && !rx_s;
    wire [4:0] break_len = long_break_select ? `UE_BREAK_LONG : `UE_BREAK_SHORT;
    wire in_brk_tx = state == uart_enh_pkg::LIN_BRK_TX;
    wire brk_tx_done = in_brk_tx && bit_tick && bit_cnt + 5'd1 == break_len;
    wire brk_rx_done = state == uart_enh_pkg::LIN_BRK_WAIT && rx_s &&
                       bit_cnt >= `UE_BREAK_DETECT;
    wire brk_done = brk_tx_done || brk_rx_done;
    // Mismatch between what we drive and what the bus shows
    wire drive_level = in_brk_tx ? 1'b0 : engine_tx_level;
    wire err_evt = lin_mode && lin_direction && bit_tick && drive_level != rx_s;
    assign abr_load = state == uart_enh_pkg::LIN_SYNC_MEAS && rx_fall &&
                      fall_cnt == `UE_SYNC_FALLS_LAST;
    assign lin_tx_out = !in_brk_tx;

    always_comb
    begin
        next_state = state;
        case (state)
            uart_enh_pkg::LIN_IDLE:
                if (lin_mode && break_control && lin_direction && wr_buf)
                    next_state = uart_enh_pkg::LIN_BRK_TX;
                else if (lin_mode && break_control && !lin_direction)
                    next_state = uart_enh_pkg::LIN_BRK_WAIT;
            uart_enh_pkg::LIN_BRK_TX:
                if (brk_tx_done)
                    next_state = uart_enh_pkg::LIN_IDLE;
            uart_enh_pkg::LIN_BRK_WAIT:
                if (!lin_mode || !break_control)
                    next_state = uart_enh_pkg::LIN_IDLE;
                else if (brk_rx_done)
                    next_state = auto_baud ? uart_enh_pkg::LIN_SYNC_WAIT :
                                 uart_enh_pkg::LIN_IDLE;
            uart_enh_pkg::LIN_SYNC_WAIT:
                if (!lin_mode || !auto_baud)
                    next_state = uart_enh_pkg::LIN_IDLE;
                else if (rx_fall)
                    next_state = uart_enh_pkg::LIN_SYNC_MEAS;
            uart_enh_pkg::LIN_SYNC_MEAS:
                if (!lin_mode || abr_load)
                    next_state = uart_enh_pkg::LIN_IDLE;
            default:
                next_state = uart_enh_pkg::LIN_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rx_meta <= 1'b1;
            rx_s <= 1'b1;
            rx_prev <= 1'b1;
        end
        else
        begin
            rx_meta <= lin_rx_pin;
            rx_s <= rx_meta;
            rx_prev <= rx_s;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state <= uart_enh_pkg::LIN_IDLE;
            sub_cnt <= '0;
            bit_cnt <= '0;
            fall_cnt <= '0;
            meas <= '0;
        end
        else
        begin
            state <= next_state;
            // Bit phase restarts with each break so its length is exact,
            // and runs freely otherwise so bus errors are still sampled
            if (state == uart_enh_pkg::LIN_IDLE && next_state != uart_enh_pkg::LIN_IDLE)
                sub_cnt <= '0;
            else if (gen_overflow)
                sub_cnt <= sub_cnt + 4'h1;
            if (state != next_state || (state == uart_enh_pkg::LIN_BRK_WAIT && rx_s))
                bit_cnt <= '0;
            else if (bit_tick && bit_cnt != 5'h1f)
                bit_cnt <= bit_cnt + 5'd1;
            if (state == uart_enh_pkg::LIN_SYNC_WAIT)
            begin
                fall_cnt <= '0;
                // The tick at the first falling edge belongs to the field
                meas <= {15'h0000, gen_clk_en};
            end
            else if (state == uart_enh_pkg::LIN_SYNC_MEAS)
            begin
                // Counts prescaled ticks; eight bits of sixteen overflows each
                if (gen_clk_en && meas != 16'hffff)
                    meas <= meas + 16'h0001;
                if (rx_fall)
                    fall_cnt <= fall_cnt + 3'd1;
            end
        end
    end

    // ============================================================
    // Control registers and read data
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            enhanced_control <= `UE_RESET_BYTE;
            address_mask_reg <= `UE_RESET_BYTE;
            lin_config <= `UE_RESET_BYTE;
            sfr_rdata <= `UE_RESET_BYTE;
            tx_flag_set <= 1'b0;
            rx_flag_set <= 1'b0;
        end
        else
        begin
            tx_flag_set <= brk_tx_done;
            rx_flag_set <= brk_rx_done;
            if (sfr_re)
                sfr_rdata <= rd_val;
            if (wr_enh)
                enhanced_control <= sfr_wdata & `UE_WRITABLE_MASK;
            if (wr_mask)
                address_mask_reg <= sfr_wdata;
            // Hardware set beats a same-cycle write-one clear
            lin_config[`UE_BIT_BRKF] <= brk_done ||
                (lin_config[`UE_BIT_BRKF] && !(wr_lin && sfr_wdata[`UE_BIT_BRKF]));
            lin_config[`UE_BIT_TXERR] <= err_evt ||
                (lin_config[`UE_BIT_TXERR] && !(wr_lin && sfr_wdata[`UE_BIT_TXERR]));
            if (wr_lin)
            begin
                lin_config[`UE_BIT_LONG] <= sfr_wdata[`UE_BIT_LONG];
                lin_config[`UE_BIT_ABR] <= sfr_wdata[`UE_BIT_ABR];
                lin_config[`UE_BIT_DIR] <= sfr_wdata[`UE_BIT_DIR];
                lin_config[`UE_BIT_BRKC] <= sfr_wdata[`UE_BIT_BRKC];
            end
            else
            begin
                if (abr_load)
                    lin_config[`UE_BIT_ABR] <= 1'b0;
                if (brk_done)
                    lin_config[`UE_BIT_BRKC] <= 1'b0;
            end
        end
    end

    // ============================================================
    // Transmit buffer; output held back while this block transmits a break (LIN_BRK_TX)
    logic fifo_valid;
    tx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(wr_buf),
        .in_data(sfr_wdata),
        .in_ready(buf_ready),
        .out_valid(fifo_valid),
        .out_data(tx_data),
        .out_ready(tx_ready && !in_brk_tx)
    );
    assign tx_valid = fifo_valid && !in_brk_tx;

    // ============================================================
    // Checks
    wire quiet = !wr_cnt && !wr_rel && !abr_load;
    property p_window_enh;
        @(posedge core_clk) disable iff (!rst_n)
        wr_enh |=> enhanced_control == ($past(sfr_wdata) & `UE_WRITABLE_MASK);
    endproperty
    a_window_enh: assert property (p_window_enh) else $error("enh write lost");
    property p_window_mask;
        @(posedge core_clk) disable iff (!rst_n)
        wr_mask |=> address_mask_reg == $past(sfr_wdata) && $stable(enhanced_control);
    endproperty
    a_window_mask: assert property (p_window_mask) else $error("mask write lost");
    property p_stopped;
        @(posedge core_clk) disable iff (!rst_n)
        !gen_run && quiet |=> baud_counter == $past(baud_counter) && !gen_overflow;
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter moved");
    property p_div12;
        @(posedge core_clk) disable iff (!rst_n)
        count_en && !gen_clock_undivided |=> !count_en [*8];
    endproperty
    a_div12: assert property (p_div12) else $error("prescale too fast");
    property p_reload;
        @(posedge core_clk) disable iff (!rst_n)
        ovf && quiet |=> gen_overflow && baud_counter == $past(baud_reload);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload");
    property p_rel_stopped;
        @(posedge core_clk) disable iff (!rst_n)
        wr_rel && !wr_cnt && !gen_run |=> baud_counter == $past(sfr_wdata);
    endproperty
    a_rel_stopped: assert property (p_rel_stopped) else $error("reload not loaded");
    property p_cnt_write;
        @(posedge core_clk) disable iff (!rst_n)
        wr_cnt && !wr_rel && !abr_load |=> baud_reload == $past(baud_reload);
    endproperty
    a_cnt_write: assert property (p_cnt_write) else $error("reload disturbed");
    property p_clk_out;
        @(posedge core_clk) disable iff (!rst_n)
        gen_overflow && clock_out_enable && $stable(clock_out_enable) && !wr_enh
        |=> clock_out_pin != $past(clock_out_pin);
    endproperty
    a_clk_out: assert property (p_clk_out) else $error("clock out stuck");
    property p_timer_only;
        @(posedge core_clk) disable iff (!rst_n)
        timer_only |-> !tx_tick && !rx_tick;
    endproperty
    a_timer_only: assert property (p_timer_only) else $error("serial tick in timer mode");
    property p_brk_flag;
        @(posedge core_clk) disable iff (!rst_n)
        brk_done |=> lin_config[`UE_BIT_BRKF] && (tx_flag_set || rx_flag_set);
    endproperty
    a_brk_flag: assert property (p_brk_flag) else $error("break flag missing");
    property p_brk_clear;
        @(posedge core_clk) disable iff (!rst_n)
        brk_done && !wr_lin |=> !break_control;
    endproperty
    a_brk_clear: assert property (p_brk_clear) else $error("break control stuck");
    c_brk_tx: cover property (@(posedge core_clk) disable iff (!rst_n) brk_tx_done);
    c_brk_rx: cover property (@(posedge core_clk) disable iff (!rst_n) brk_rx_done);
    c_abr: cover property (@(posedge core_clk) disable iff (!rst_n) abr_load);
    c_full: cover property (@(posedge core_clk) disable iff (!rst_n) !buf_ready);
endmodule : uart_enhanced_baud_lin
`default_nettype wire

// ===== design/uart_enh_consts.svh
// Register map, field positions and timing constants of the enhanced serial block
`ifndef UART_ENH_CONSTS_SVH
`define UART_ENH_CONSTS_SVH
`define UE_ADDR_BUFFER 8'h99
`define UE_ADDR_RELOAD 8'h9a
`define UE_ADDR_COUNTER 8'h9b
`define UE_ADDR_LIN_CFG 8'h9d
`define UE_ADDR_SHARED 8'hb9
`define UE_RESET_BYTE 8'h00
`define UE_WRITABLE_MASK 8'hfc
`define UE_COUNTER_FULL 8'hff
`define UE_PRESCALE_LAST 4'hb
`define UE_BIT_RUN 7
`define UE_BIT_UNDIV 6
`define UE_BIT_TXGEN 5
`define UE_BIT_RXGEN 4
`define UE_BIT_CKOE 3
`define UE_BIT_ART 2
`define UE_BIT_BRKF 7
`define UE_BIT_TXERR 6
`define UE_BIT_LONG 5
`define UE_BIT_ABR 4
`define UE_BIT_DIR 3
`define UE_BIT_BRKC 2
`define UE_MODE_UART8 3'b001
`define UE_MODE_FIXED9 3'b010
`define UE_MODE_UART9 3'b011
`define UE_MODE_LIN 3'b101
`define UE_OVF_PER_BIT_LAST 4'hf
`define UE_BREAK_SHORT 5'd13
`define UE_BREAK_LONG 5'd16
`define UE_BREAK_DETECT 5'd11
`define UE_SYNC_FALLS_LAST 3'd3
`endif

// ===== design/uart_enh_pkg.sv
// Types shared by the enhanced serial block
package uart_enh_pkg;
    typedef enum logic [2:0] {
        LIN_IDLE,
        LIN_BRK_TX,
        LIN_BRK_WAIT,
        LIN_SYNC_WAIT,
        LIN_SYNC_MEAS
    } lin_state_t;
endpackage : uart_enh_pkg

// ===== bench/lin_node_model.sv
// Remote LIN node: wired bus level and a slow stream sink
`timescale 1ns/1ps
`default_nettype none

module lin_node_model (
    input wire logic core_clk,
    input wire logic lin_tx_out,
    input wire logic pull_low,
    input wire logic stall,
    output logic tx_ready,
    output logic lin_rx_pin
);
    // Wired-AND bus with pull-up, so a released bus reads high
    assign lin_rx_pin = lin_tx_out & ~pull_low;
    initial tx_ready = 1'b0;
    // Accepts on random cycles only, to keep the FIFO output under back-pressure
    always @(posedge core_clk)
    begin
        tx_ready <= ~stall & ($urandom % 2 == 0);
    end
endmodule : lin_node_model

`default_nettype wire

// ===== bench/uart_enhanced_baud_lin_test.sv
// Self-checking bench for the enhanced serial block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end

module uart_enhanced_baud_lin_test;
    logic core_clk = 1'b0, rst_n = 1'b0, sfr_we = 1'b0, sfr_re = 1'b0, re_d = 1'b0;
    logic window_select = 1'b0, default_tick = 1'b0, engine_tx_level = 1'b1;
    logic pull_low = 1'b0, stall = 1'b0, chk_on = 1'b0, co_d = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, address_mask_reg, tx_data, b;
    logic [2:0] serial_mode = 3'b001;
    logic [1:0] sel = 2'b00;
    logic gen_overflow, tx_tick, rx_tick, timer_only, lin_mode, auto_repeat_tx, clock_out_pin;
    logic clock_out_pin_oe, lin_rx_pin, lin_tx_out, tx_flag_set, rx_flag_set, tx_valid;
    logic tx_ready, buf_ready;
    logic [7:0] rv, tv;
    // Expected timer-only state from the stimulus side
    wire to_exp = serial_mode == 3'b010 && sel == 2'b11;
    logic [7:0] rd_q[$], exp_q[$];
    logic [2:0] modes[4] = '{3'b001, 3'b010, 3'b011, 3'b101};
    int err_total = 0, cmp_count = 0, ovf_n = 0, tog_n = 0, tfl_n = 0, rfl_n = 0, n, w;

    always #2 core_clk = ~core_clk;

    uart_enhanced_baud_lin dut_u (.core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata),
        .window_select(window_select), .serial_mode(serial_mode),
        .default_tick(default_tick), .gen_overflow(gen_overflow), .tx_tick(tx_tick),
        .rx_tick(rx_tick), .timer_only(timer_only), .lin_mode(lin_mode),
        .auto_repeat_tx(auto_repeat_tx), .address_mask_reg(address_mask_reg),
        .clock_out_pin(clock_out_pin), .clock_out_pin_oe(clock_out_pin_oe),
        .lin_rx_pin(lin_rx_pin), .engine_tx_level(engine_tx_level), .lin_tx_out(lin_tx_out),
        .tx_flag_set(tx_flag_set), .rx_flag_set(rx_flag_set), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .buf_ready(buf_ready));

    lin_node_model node_u (.core_clk(core_clk), .lin_tx_out(lin_tx_out), .pull_low(pull_low),
        .stall(stall), .tx_ready(tx_ready), .lin_rx_pin(lin_rx_pin));

    // ============================================================
    // Output monitor: takes the oldest note whenever a result shows
    always @(posedge core_clk)
    begin
        default_tick <= 1'($urandom % 2);
        re_d <= sfr_re;
        co_d <= clock_out_pin;
        ovf_n += int'(gen_overflow);
        tog_n += int'(clock_out_pin != co_d);
        tfl_n += int'(tx_flag_set);
        rfl_n += int'(rx_flag_set);
        if (re_d)
        begin
            rv = rd_q.pop_front();
            `CHK("rdata", rv, sfr_rdata)
        end
        if (tx_valid && tx_ready)
        begin
            tv = exp_q.pop_front();
            `CHK("tx_data", tv, tx_data)
        end
        if (chk_on)
        begin
            `CHK("tx_tick", to_exp ? 1'b0 : sel[1] ? gen_overflow : default_tick, tx_tick)
            `CHK("rx_tick", to_exp ? 1'b0 : sel[0] ? gen_overflow : default_tick, rx_tick)
        end
    end

    // ============================================================
    // Register access and measurement tasks
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_we <= 1'b1;
        cyc(1);
        sfr_we <= 1'b0;
        cyc(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        sfr_addr <= a;
        sfr_re <= 1'b1;
        cyc(1);
        sfr_re <= 1'b0;
        cyc(1);
    endtask : rd

    // Slack of one absorbs the edge at which the counters are cleared
    task automatic meas(input int k, input int e);
        ovf_n = 0;
        tog_n = 0;
        cyc(k);
        `CHK("ovf", 1'b1, ovf_n >= e - 1 && ovf_n <= e + 1)
        `CHK("clk_out", 1'b1, tog_n >= ovf_n - 1 && tog_n <= ovf_n + 1)
    endtask : meas

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    initial
    begin
        cyc(20000);
        err_total++;
        conclude();
    end

    // ============================================================
    // Main sequence
    initial
    begin
        void'($urandom(32'hc672));
        cyc(4);
        rst_n <= 1'b1;
        cyc(1);
        window_select <= 1'b1;
        rd(8'h9a, 8'h00);
        rd(8'h9b, 8'h00);
        rd(8'h9d, 8'h00);
        rd(8'hb9, 8'h00);
        rd(8'h80, 8'h00);
        b = 8'($urandom);
        window_select <= 1'b0;
        wr(8'hb9, b);
        `CHK("mask", b, address_mask_reg)
        rd(8'hb9, b);
        window_select <= 1'b1;
        wr(8'hb9, 8'h04);
        rd(8'hb9, 8'h04);
        `CHK("art", 1'b1, auto_repeat_tx)
        `CHK("mask_kept", b, address_mask_reg)
        wr(8'h9a, 8'hfc);
        rd(8'h9b, 8'hfc);
        wr(8'h9b, 8'h10);
        rd(8'h9a, 8'hfc);
        rd(8'h9b, 8'h10);
        wr(8'h9b, 8'hfc);
        wr(8'hb9, 8'hc8);
        meas(400, 100);
        `CHK("oe", 1'b1, clock_out_pin_oe)
        wr(8'hb9, 8'h88);
        meas(480, 10);
        wr(8'hb9, 8'h08);
        meas(200, 0);
        for (int i = 0; i < 16; i++)
        begin
            chk_on <= 1'b0;
            serial_mode <= modes[i / 4];
            sel <= 2'(i);
            wr(8'hb9, {2'b11, 2'(i), 4'h0});
            chk_on <= 1'b1;
            cyc(24);
            `CHK("lin", i / 4 == 3 && i % 4 == 3, lin_mode)
            `CHK("timer", i / 4 == 1 && i % 4 == 3, timer_only)
            `CHK("oe_off", 1'b0, clock_out_pin_oe)
        end
        chk_on <= 1'b0;
        // One overflow per cycle gives 16 cycles per bit
        wr(8'hb9, 8'h00);
        wr(8'h9a, 8'hff);
        wr(8'hb9, 8'hf0);
        for (int lg = 0; lg < 2; lg++)
        begin
            wr(8'h9d, lg ? 8'h2c : 8'h0c);
            b = 8'($urandom);
            exp_q.push_back(b);
            wr(8'h99, b);
            for (w = 0; w < 100 && lin_tx_out !== 1'b0; w++) cyc(1);
            for (n = 0; n < 400 && lin_tx_out === 1'b0; n++) cyc(1);
            `CHK("brk_len", 1'b1, n >= (lg ? 254 : 206) && n <= (lg ? 258 : 210))
            cyc(20);
            `CHK("tx_flag", lg + 1, tfl_n)
            rd(8'h9d, lg ? 8'ha8 : 8'h88);
            wr(8'h9d, lg ? 8'ha8 : 8'h88);
            rd(8'h9d, lg ? 8'h28 : 8'h08);
        end
        pull_low <= 1'b1;
        cyc(40);
        pull_low <= 1'b0;
        rd(8'h9d, 8'h68);
        wr(8'h9d, 8'h40);
        rd(8'h9d, 8'h00);
        wr(8'h9d, 8'h14);
        pull_low <= 1'b1;
        cyc(200);
        pull_low <= 1'b0;
        cyc(64);
        `CHK("rx_flag", 1, rfl_n)
        // Sync field: start bit, alternating data, stop bit, 64 cycles a bit
        w = 32'h2aa;
        for (int k = 0; k < 10; k++)
        begin
            pull_low <= ~w[k];
            cyc(64);
        end
        cyc(10);
        rd(8'h9d, 8'h80);
        rd(8'h9a, 8'hfc);
        serial_mode <= 3'b001;
        stall <= 1'b1;
        cyc(3);
        for (int k = 0; k < 32; k++)
        begin
            b = 8'($urandom);
            exp_q.push_back(b);
            wr(8'h99, b);
        end
        `CHK("full", 1'b0, buf_ready)
        wr(8'h99, 8'hee);
        stall <= 1'b0;
        for (w = 0; w < 600 && exp_q.size() > 0; w++) cyc(1);
        `CHK("drained", 0, exp_q.size())
        conclude();
    end
endmodule : uart_enhanced_baud_lin_test

`default_nettype wire
